// File: kstr_defines.vh
// Register addresses, field positions, reset values and timing for key status/test bank
`ifndef KSTR_DEFINES_VH
`define KSTR_DEFINES_VH
`define KSTR_ADDR_TEST      8'h07
`define KSTR_ADDR_STICKY    8'h08
`define KSTR_ADDR_LIVE      8'h0C
`define KSTR_TEST_BIT       0
`define KSTR_RST_TEST       1'b0
`define KSTR_RST_KEYS       8'h00
`define KSTR_TEST_DUTY      6'h1C
`define KSTR_PWM_STEPS      6'h3F
`endif

// File: kstr_regs.v
// Key status registers and display test override of the LED driver
`timescale 1ns/1ps
`include "kstr_defines.vh"
module kstr_regs
(
	input  wire       mclk_i,
	input  wire       rst_n_i,
	input  wire       clk_en_i,
	input  wire       wr_stb_i,
	input  wire       rd_stb_i,
	input  wire [7:0] addr_i,
	input  wire [7:0] wdata_i,
	input  wire       scan_done_i,
	input  wire [7:0] scan_pressed_i,
	input  wire [7:0] scan_debounced_i,
	input  wire [5:0] intensity_i,
	input  wire       shutdown_i,
	input  wire [7:0] seg_pattern_i,
	output reg  [7:0] rdata_o,
	output reg        rvalid_o,
	output reg        irq_o,
	output reg        test_mode_o,
	output reg  [7:0] seg_drive_o,
	output reg        pwm_on_o
);

// ----------------------------------------------------------------
// State and next-state values
// ----------------------------------------------------------------
reg  [7:0] live_reg;
reg  [7:0] live_next;
reg  [7:0] released_reg;
reg  [7:0] released_next;
reg  [7:0] sticky_reg;
reg  [7:0] sticky_next;
reg        irq_next;
reg        clr_pend_reg;
reg        clr_pend_next;
reg        test_reg;
reg        test_next;
reg  [7:0] rdata_next;
reg        rvalid_next;
reg  [5:0] pwm_cnt_reg;
reg  [5:0] pwm_cnt_next;
reg        pwm_on_next;
reg  [7:0] seg_next;
wire [7:0] new_evt;
wire [5:0] duty;
wire       rd_sticky;
wire       wr_test;

// ----------------------------------------------------------------
// Helper functions
// ----------------------------------------------------------------
// Strobe qualified by a register pointer match
function addr_hit;
	input       stb;
	input [7:0] ptr;
	input [7:0] code;
	begin
		addr_hit = stb && (ptr == code);
	end
endfunction

// Unmapped pointers read as zero
function [7:0] read_mux;
	input [7:0] ptr;
	input       test_bit;
	input [7:0] sticky;
	input [7:0] live;
	begin
		case (ptr)
		`KSTR_ADDR_TEST:   read_mux = {7'h00, test_bit};
		`KSTR_ADDR_STICKY: read_mux = sticky;
		`KSTR_ADDR_LIVE:   read_mux = live;
		default:           read_mux = 8'h00;
		endcase
	end
endfunction

// ----------------------------------------------------------------
// Event qualification
// ----------------------------------------------------------------
// Only keys seen released since their last report may fire again
assign new_evt   = scan_done_i ? (scan_debounced_i & released_reg)
	: 8'h00;
assign rd_sticky = addr_hit(rd_stb_i, addr_i, `KSTR_ADDR_STICKY);
// Only the test register accepts writes; 0x08 and 0x0C fall through
assign wr_test   = addr_hit(wr_stb_i, addr_i, `KSTR_ADDR_TEST);
assign duty      = test_reg ? `KSTR_TEST_DUTY : intensity_i;

// ----------------------------------------------------------------
// Key tracking next state
// ----------------------------------------------------------------
always @*
begin
	live_next     = live_reg;
	released_next = released_reg;
	if (scan_done_i)
	begin
		live_next     = scan_pressed_i;
		// A key re-arms once a scan finds it up
		released_next = (released_reg & ~scan_debounced_i)
			| ~scan_pressed_i;
	end
end

// ----------------------------------------------------------------
// Sticky events and interrupt next state
// ----------------------------------------------------------------
always @*
begin
	// Clear after data left; a same-cycle event survives
	if (clr_pend_reg)
	begin
		sticky_next = new_evt;
		irq_next    = |new_evt;
	end
	else
	begin
		sticky_next = sticky_reg | new_evt;
		irq_next    = irq_o | (|new_evt);
	end
	clr_pend_next = rd_sticky;
end

// ----------------------------------------------------------------
// Host port next state
// ----------------------------------------------------------------
always @*
begin
	test_next   = test_reg;
	rdata_next  = rdata_o;
	rvalid_next = rd_stb_i;
	if (wr_test)
		test_next = wdata_i[`KSTR_TEST_BIT];
	// Live reads have no side effect
	if (rd_stb_i)
		rdata_next = read_mux(addr_i, test_reg, sticky_reg,
			live_reg);
end

// ----------------------------------------------------------------
// Display override next state
// ----------------------------------------------------------------
always @*
begin
	if (pwm_cnt_reg == `KSTR_PWM_STEPS)
		pwm_cnt_next = 6'h00;
	else
		pwm_cnt_next = pwm_cnt_reg + 6'h01;
	// Test mode lights the LEDs even in shutdown
	pwm_on_next = (pwm_cnt_reg < duty)
		&& (test_reg || !shutdown_i);
	// Stored settings untouched; override only on the output path
	seg_next = test_reg ? 8'hFF : seg_pattern_i;
end

// ----------------------------------------------------------------
// Key tracking registers
// ----------------------------------------------------------------
always @(posedge mclk_i or negedge rst_n_i)
begin
	if (!rst_n_i)
	begin
		live_reg     <= `KSTR_RST_KEYS;
		// All keys armed, so the first press is reported
		released_reg <= 8'hFF;
	end
	else if (clk_en_i)
	begin
		live_reg     <= live_next;
		released_reg <= released_next;
	end
end

// ----------------------------------------------------------------
// Sticky events and interrupt registers
// ----------------------------------------------------------------
always @(posedge mclk_i or negedge rst_n_i)
begin
	if (!rst_n_i)
	begin
		sticky_reg   <= `KSTR_RST_KEYS;
		irq_o        <= 1'b0;
		clr_pend_reg <= 1'b0;
	end
	else if (clk_en_i)
	begin
		sticky_reg   <= sticky_next;
		irq_o        <= irq_next;
		clr_pend_reg <= clr_pend_next;
	end
end

// ----------------------------------------------------------------
// Host port registers
// ----------------------------------------------------------------
always @(posedge mclk_i or negedge rst_n_i)
begin
	if (!rst_n_i)
	begin
		test_reg    <= `KSTR_RST_TEST;
		rdata_o     <= 8'h00;
		rvalid_o    <= 1'b0;
		test_mode_o <= 1'b0;
	end
	else if (clk_en_i)
	begin
		test_reg    <= test_next;
		rdata_o     <= rdata_next;
		rvalid_o    <= rvalid_next;
		test_mode_o <= test_reg;
	end
end

// ----------------------------------------------------------------
// Display override registers
// ----------------------------------------------------------------
always @(posedge mclk_i or negedge rst_n_i)
begin
	if (!rst_n_i)
	begin
		pwm_cnt_reg <= 6'h00;
		pwm_on_o    <= 1'b0;
		seg_drive_o <= 8'h00;
	end
	else if (clk_en_i)
	begin
		pwm_cnt_reg <= pwm_cnt_next;
		pwm_on_o    <= pwm_on_next;
		seg_drive_o <= seg_next;
	end
end

endmodule // kstr_regs

// File: kstr_host.sv
// Host model: register pointer writes and data reads
`timescale 1ns/1ps
module kstr_host
(
	input  wire       mclk_i,
	input  wire [7:0] rdata_i,
	input  wire       rvalid_i,
	output reg        wr_o,
	output reg        rd_o,
	output reg  [7:0] a_o,
	output reg  [7:0] d_o
);
	initial {wr_o, rd_o, a_o, d_o} = 18'h0;
	// One byte per call; the answer is taken one edge after the strobe
	task acc(input w, input [7:0] a, input [7:0] d, output [7:0] q,
		output v);
	begin
		{wr_o, rd_o, a_o, d_o} <= {w, !w, a, d};
		@(posedge mclk_i) {wr_o, rd_o} <= 2'h0;
		@(posedge mclk_i);
		q = rdata_i;
		v = rvalid_i;
	end
	endtask
endmodule // kstr_host

// File: kstr_regs_asserts.sv
// Checker of the key status bank
`timescale 1ns/1ps
module kstr_regs_asserts
(
	input wire       mclk_i,
	input wire       rst_n_i,
	input wire       clk_en_i,
	input wire       rd_stb_i,
	input wire [7:0] addr_i,
	input wire       scan_done_i,
	input wire       rvalid_o,
	input wire       irq_o,
	input wire       test_mode_o,
	input wire [7:0] seg_drive_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	a_read_answer: assert property (
		rd_stb_i && clk_en_i |=> rvalid_o) else $error("no answer");
	a_no_stray: assert property (
		!rd_stb_i && clk_en_i |=> !rvalid_o) else $error("stray");
	a_live_quiet: assert property (
		rd_stb_i && addr_i == 8'h0C && !scan_done_i
		&& !rvalid_o |=> $stable(irq_o)) else $error("irq moved");
	a_sticky_clear: assert property (
		rd_stb_i && addr_i == 8'h08 && clk_en_i ##1 !scan_done_i && clk_en_i
		|=> !irq_o) else $error("irq kept");
	a_irq_no_cause: assert property (
		!irq_o && !scan_done_i |=> !irq_o) else $error("irq unprompted");
	a_test_segs: assert property (
		test_mode_o |-> seg_drive_o == 8'hFF) else $error("segments dark");
	cover property (irq_o ##[1:9] !irq_o);
	cover property (rvalid_o);
	cover property (rd_stb_i && addr_i == 8'h0C && irq_o);
endmodule // kstr_regs_asserts
bind kstr_regs kstr_regs_asserts i_chk(.*);

// File: key_status_display_test_regs_tb.sv
// Bench of the key status bank
`timescale 1ns/1ps
module key_status_display_test_regs_tb;
	reg        mclk_i = 0, rst_n_i = 0, sd = 0;
	reg  [7:0] sp = 8'h00;
	wire       wr, rd, rv, irq, tm, pwm;
	wire [7:0] a, d, q, seg;
	integer    n_errors = 0, checks = 0, n;
	always #20 mclk_i = ~mclk_i;
	kstr_host i_host(.mclk_i(mclk_i), .rdata_i(q), .rvalid_i(rv), .wr_o(wr),
		.rd_o(rd), .a_o(a), .d_o(d));
	kstr_regs i_dut(.mclk_i(mclk_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1),
		.wr_stb_i(wr), .rd_stb_i(rd), .addr_i(a), .wdata_i(d), .scan_done_i(sd),
		.scan_pressed_i(sp), .scan_debounced_i(sp), .intensity_i(6'h08),
		.shutdown_i(1'b1), .seg_pattern_i(8'h00), .rdata_o(q), .rvalid_o(rv),
		.irq_o(irq), .test_mode_o(tm), .seg_drive_o(seg), .pwm_on_o(pwm));
	task chk(input [95:0] s, input [7:0] e, g);
	begin
		checks = checks + 1;
		if (g !== e)
		begin
			n_errors = n_errors + 1;
			$display("wrong value %0s exp %h got %h", s, e, g);
		end
	end
	endtask
	task rdr(input [7:0] ad, input [7:0] e);
		reg [7:0] r;
		reg       v;
	begin
		i_host.acc(1'b0, ad, 8'h00, r, v);
		chk("rvalid", 8'h01, {7'h00, v});
		chk("rdata", e, r);
	end
	endtask
	task wrr(input [7:0] ad, input [7:0] dt);
		reg [7:0] r;
		reg       v;
	begin
		i_host.acc(1'b1, ad, dt, r, v);
		chk("rvalid", 8'h00, {7'h00, v});
	end
	endtask
	task irq_is(input e);
	begin
		@(posedge mclk_i);
		chk("irq", {7'h00, e}, {7'h00, irq});
	end
	endtask
	task duty_is(input [7:0] e);
	begin
		n = 0;
		repeat (64)
		begin
			@(posedge mclk_i);
			n = n + pwm;
		end
		chk("duty", e, n[7:0]);
	end
	endtask
	task scan(input [7:0] p);
	begin
		{sp, sd} <= {p, 1'b1};
		@(posedge mclk_i) sd <= 1'b0;
		repeat (3) @(posedge mclk_i);
	end
	endtask
	task t_keys;
	begin
		scan(8'h81);
		rdr(8'h0C, 8'h81);
		irq_is(1'b1);
		wrr(8'h08, 8'h00);
		wrr(8'h0C, 8'h00);
		rdr(8'h0C, 8'h81);
		rdr(8'h08, 8'h81);
		irq_is(1'b0);
		rdr(8'h08, 8'h00);
		scan(8'h81);
		rdr(8'h08, 8'h00);
		irq_is(1'b0);
		scan(8'h00);
		rdr(8'h0C, 8'h00);
		scan(8'h01);
		scan(8'h02);
		rdr(8'h08, 8'h03);
		rdr(8'h0C, 8'h02);
		$display("keys done");
	end
	endtask
	task t_test;
	begin
		wrr(8'h07, 8'hFE);
		rdr(8'h07, 8'h00);
		chk("test_mode", 8'h00, {7'h00, tm});
		wrr(8'h07, 8'h01);
		rdr(8'h07, 8'h01);
		chk("test_mode", 8'h01, {7'h00, tm});
		chk("seg", 8'hFF, seg);
		duty_is(8'h1C);
		rdr(8'h0C, 8'h02);
		wrr(8'h07, 8'h00);
		rdr(8'h07, 8'h00);
		chk("test_mode", 8'h00, {7'h00, tm});
		chk("seg", 8'h00, seg);
		duty_is(8'h00);
		$display("test done");
	end
	endtask
	task end_of_test;
	begin
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end
	endtask
	initial
	begin
		repeat (20) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		@(posedge mclk_i) t_keys;
		t_test;
		end_of_test;
	end
	initial
	begin
		#200000 n_errors = n_errors + 1;
		end_of_test;
	end
endmodule // key_status_display_test_regs_tb
